// ===== bus_agent.sv
/*
  Model of the processor and dma requesters on the internal bus.
  Assumes the store takes a request at one edge and answers in the next cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_agent (
  input wire logic clk,
  output logic req,
  output var rom_pkg::master_e master,
  output var rom_pkg::size_e size,
  output logic write,
  output logic [rom_pkg::BUS_ADDR_W-1:0] addr,
  input wire logic ack,
  input wire logic err,
  input wire logic [rom_pkg::BUS_DATA_W-1:0] rdata
);
  import rom_pkg::*;
  initial begin
    req = 1'b0;
    master = MASTER_CPU;
    size = SIZE_BYTE;
    write = 1'b0;
    addr = 28'h0000000;
  end
  // one request per call; answer sampled in the cycle after the taking edge
  task automatic access(input master_e m, input size_e s, input logic w,
                        input logic [BUS_ADDR_W-1:0] a, output logic [1:0] ke,
                        output logic [BUS_DATA_W-1:0] d);
    @(posedge clk);
    req <= 1'b1;
    master <= m;
    size <= s;
    write <= w;
    addr <= a;
    @(posedge clk);
    req <= 1'b0;
    addr <= ~a; // released lines must not keep the old address
    // the answer stands for one cycle only; take it mid-cycle, not on the edge
    @(negedge clk);
    ke = {ack, err};
    d = rdata;
  endtask
endmodule
`default_nettype wire

// ===== mem_if.sv
/*
  Port bundle between a requester and the storage array.
  Assumes the array answers read data one clock after the request.
*/
`timescale 1ns/1ps
`default_nettype none
interface mem_if;
  import rom_pkg::*;
  logic en;
  logic we;
  logic [WADDR_W-1:0] addr;
  logic [LANES-1:0] lanes;
  logic [BUS_DATA_W-1:0] wdata;
  logic [BUS_DATA_W-1:0] rdata;
  modport req (output en, output we, output addr, output lanes, output wdata, input rdata);
  modport mem (input en, input we, input addr, input lanes, input wdata, output rdata);
endinterface
`default_nettype wire

// ===== onchip_rom.sv
/*
  On-chip program store: one-cycle reads from the processor and the dma
  controller, mode-pin selection, area 0 shadow decode and the byte-wide
  programming port. Assumes an outside decoder routes only area 0 cycles
  here and resolves the programming data pins from the enable.
*/
`timescale 1ns/1ps
`default_nettype none
module onchip_rom (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [2:0] op_mode_pins,
  input wire logic bus_req,
  input wire rom_pkg::master_e bus_master,
  input wire rom_pkg::size_e bus_size,
  input wire logic bus_write,
  input wire logic [rom_pkg::BUS_ADDR_W-1:0] bus_addr,
  output logic bus_ack,
  output logic bus_err,
  output logic [rom_pkg::BUS_DATA_W-1:0] bus_rdata,
  output logic rom_enabled,
  output logic area0_external,
  output logic area0_bus16,
  output logic prom_mode,
  input wire logic prog_ce_n,
  input wire logic prog_oe_n,
  input wire logic program_pulse_n,
  input wire logic [rom_pkg::PROG_ADDR_W-1:0] prog_address_lines,
  input wire logic [rom_pkg::BYTE_W-1:0] prog_data_lines_i,
  output logic [rom_pkg::BYTE_W-1:0] prog_data_lines_o,
  output logic prog_data_lines_oe
);
  import rom_pkg::*;

  mem_if arr_if ();
  mem_if prog_if ();

  mode_e mode_r;
  logic rom_en_r;
  logic ext_r;
  logic bus16_r;
  logic prom_r;
  logic ack_r;
  logic err_r;
  logic verify_d_r;
  logic upper_d_r;
  logic [BYTE_W-1:0] dout_r;
  logic doe_r;
  logic [LANES-1:0] lane_chk_r;
  logic verify_w;
  logic upper_w;
  logic area0_hit;
  logic rom_req;
  logic refused;
  logic rd_go;
  logic [LANES-1:0] bus_lanes;

  function automatic mode_e mode_of(logic [2:0] pins);
    unique case (pins)
      MODE_PINS_EXT8: mode_of = MODE_EXT8;
      MODE_PINS_EXT16: mode_of = MODE_EXT16;
      MODE_PINS_ROM: mode_of = MODE_ROM;
      MODE_PINS_PROM: mode_of = MODE_PROM;
      default: mode_of = MODE_RSVD;
    endcase
  endfunction

  // mode pins are straps; taken every clock, so a change lands one edge later
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= MODE_EXT8;
    end else begin
      mode_r <= mode_of(op_mode_pins);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_en_r <= 1'b0;
      ext_r <= 1'b1;
      bus16_r <= 1'b0;
      prom_r <= 1'b0;
    end else begin
      rom_en_r <= (mode_of(op_mode_pins) == MODE_ROM);
      ext_r <= (mode_of(op_mode_pins) == MODE_EXT8)
        || (mode_of(op_mode_pins) == MODE_EXT16);
      bus16_r <= (mode_of(op_mode_pins) == MODE_EXT16);
      prom_r <= (mode_of(op_mode_pins) == MODE_PROM);
    end
  end

  // only bits 26:24 select area 0, so bit 27 folds the upper window onto
  // the lower, and bits 23:16 are ignored so every 64 kbyte shadow aliases
  assign area0_hit = bus_req && (bus_addr[AREA_HI:AREA_LO] == AREA0_SEL);
  assign rom_req = area0_hit && (mode_r == MODE_ROM);
  assign refused = ((bus_master == MASTER_DMA) && (bus_size == SIZE_WORD))
    || (bus_size == SIZE_RSVD);
  // writes are acknowledged but never reach the array
  assign rd_go = rom_req && !bus_write && !refused;
  assign bus_lanes = lane_mask(bus_size, bus_addr[WORD_LSB-1:0]);

  // the array has one port; the programmer owns it only in programming mode
  always_comb begin
    if (prom_r) begin
      arr_if.en = prog_if.en;
      arr_if.we = prog_if.we;
      arr_if.addr = prog_if.addr;
      arr_if.lanes = prog_if.lanes;
      arr_if.wdata = prog_if.wdata;
    end else begin
      arr_if.en = rd_go;
      arr_if.we = 1'b0;
      arr_if.addr = bus_addr[ROM_OFF_HI:WORD_LSB];
      arr_if.lanes = rd_go ? bus_lanes : LANES_NONE;
      arr_if.wdata = '0;
    end
  end
  assign prog_if.rdata = arr_if.rdata;

  rom_array u_array (
    .clk(ref_clk),
    .rst_n(rst_n),
    .port(arr_if.mem)
  );

  prog_port_ctrl u_prog (
    .clk(ref_clk),
    .rst_n(rst_n),
    .active(prom_r),
    .prog_ce_n(prog_ce_n),
    .prog_oe_n(prog_oe_n),
    .program_pulse_n(program_pulse_n),
    .prog_address_lines(prog_address_lines),
    .prog_din(prog_data_lines_i),
    .verify(verify_w),
    .upper(upper_w),
    .port(prog_if.req)
  );

  // answer on the very next edge: no wait states whatever the size or master
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      ack_r <= rom_req && !refused;
      err_r <= rom_req && refused;
    end
  end

  // helper for checking the lane placement of the answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_chk_r <= LANES_NONE;
    end else begin
      lane_chk_r <= rd_go ? bus_lanes : LANES_NONE;
    end
  end

  // verify path: pins, array read, then the output register; 100 ns in all,
  // inside the access time the programmer allows
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      verify_d_r <= 1'b0;
      upper_d_r <= 1'b0;
    end else begin
      verify_d_r <= verify_w;
      upper_d_r <= upper_w;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_r <= ERASED_BYTE;
    end else if (upper_d_r) begin
      dout_r <= ERASED_BYTE;
    end else begin
      dout_r <= arr_if.rdata[31:24] | arr_if.rdata[23:16]
        | arr_if.rdata[15:8] | arr_if.rdata[7:0];
    end
  end

  // drop the enable as soon as the verify code goes, so floating is quick
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      doe_r <= 1'b0;
    end else begin
      doe_r <= verify_d_r && verify_w;
    end
  end

  assign bus_ack = ack_r;
  assign bus_err = err_r;
  assign bus_rdata = arr_if.rdata;
  assign rom_enabled = rom_en_r;
  assign area0_external = ext_r;
  assign area0_bus16 = bus16_r;
  assign prom_mode = prom_r;
  assign prog_data_lines_o = dout_r;
  assign prog_data_lines_oe = doe_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_verify_held;
    verify_w [*3];
  endsequence

  sequence s_upper_verify;
    (verify_w && upper_w) [*3];
  endsequence

  a_read_one_cycle: assert property (
    rom_req && !refused |=> bus_ack && !bus_err)
    else $error("store access not answered on the next edge");

  a_dma_word_refused: assert property (
    rom_req && (bus_master == MASTER_DMA) && (bus_size == SIZE_WORD)
      |=> bus_err && !bus_ack)
    else $error("dma word access was not refused");

  a_lane_placement: assert property (
    bus_ack && !prom_mode |-> (bus_rdata & ~{{8{lane_chk_r[3]}}, {8{lane_chk_r[2]}},
      {8{lane_chk_r[1]}}, {8{lane_chk_r[0]}}}) == '0)
    else $error("read data outside the addressed lanes");

  a_rom_mode_map: assert property (
    rst_n && op_mode_pins == MODE_PINS_ROM |=> rom_enabled && !area0_external && !prom_mode)
    else $error("mode 2 did not enable the store");

  a_ext_mode_width: assert property (
    rst_n && op_mode_pins == MODE_PINS_EXT16 |=> area0_external && area0_bus16 && !rom_enabled)
    else $error("mode 1 did not select 16-bit external area 0");

  a_no_ack_off: assert property (
    bus_req && (mode_r != MODE_ROM) |=> !bus_ack && !bus_err)
    else $error("answer given while the store is unmapped");

  a_shadow_addr: assert property (
    rd_go |-> arr_if.en && (arr_if.addr == bus_addr[ROM_OFF_HI:WORD_LSB]))
    else $error("shadow access did not reach the aliased word");

  a_prom_entry: assert property (
    rst_n && op_mode_pins == MODE_PINS_PROM |=> prom_mode && !rom_enabled)
    else $error("all-high mode pins did not enter programming mode");

  a_bus_write_blocked: assert property (
    arr_if.we |-> prom_mode && !rd_go)
    else $error("store written outside programming mode");

  a_one_byte_pulse: assert property (
    arr_if.we |-> $countones(arr_if.lanes) == 1 ##1 !arr_if.we)
    else $error("more than one byte written per operation");

  a_verify_drive: assert property (
    s_verify_held |-> prog_data_lines_oe)
    else $error("verify code held but data lines not driven");

  a_upper_erased: assert property (
    s_upper_verify |-> prog_data_lines_o == ERASED_BYTE)
    else $error("upper half did not read as all ones");

  a_inhibit_float: assert property (
    !verify_w |=> !prog_data_lines_oe)
    else $error("data lines driven outside the verify code");
endmodule
`default_nettype wire

// ===== prog_port_ctrl.sv
/*
  Decodes the byte-wide programming pins into store requests.
  Assumes the pins are synchronous to clk and only matter in programming mode.
*/
`timescale 1ns/1ps
`default_nettype none
module prog_port_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic prog_ce_n,
  input wire logic prog_oe_n,
  input wire logic program_pulse_n,
  input wire logic [rom_pkg::PROG_ADDR_W-1:0] prog_address_lines,
  input wire logic [rom_pkg::BYTE_W-1:0] prog_din,
  output logic verify,
  output logic upper,
  mem_if.req port
);
  import rom_pkg::*;

  logic write_code;
  logic wr_seen_r;
  logic wr_go;

  assign write_code = active && !prog_ce_n && prog_oe_n && !program_pulse_n;
  assign verify = active && !prog_ce_n && !prog_oe_n && program_pulse_n;
  assign upper = prog_address_lines[PROG_HALF_BIT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_seen_r <= 1'b0;
    end else begin
      wr_seen_r <= write_code;
    end
  end

  // one byte per pulse; the upper half has no cells behind it
  assign wr_go = write_code && !wr_seen_r && !upper;
  assign port.en = wr_go || verify;
  assign port.we = wr_go;
  assign port.addr = prog_address_lines[ROM_OFF_HI:WORD_LSB];
  assign port.lanes = lane_mask(SIZE_BYTE, prog_address_lines[WORD_LSB-1:0]);
  assign port.wdata = {LANES{prog_din}};
endmodule
`default_nettype wire

// ===== rom_array.sv
/*
  64 kbyte store as four byte banks with a registered read port.
  Assumes one requester at a time; unread lanes come back as zero.
*/
`timescale 1ns/1ps
`default_nettype none
module rom_array (
  input wire logic clk,
  input wire logic rst_n,
  mem_if.mem port
);
  import rom_pkg::*;

  genvar g;
  for (g = 0; g < LANES; g++) begin : g_lane
    logic [BYTE_W-1:0] bank [ROM_WORDS];
    logic [BYTE_W-1:0] rd_r;
    // cells have no reset, so a write stores the byte as given; an and with
    // the old contents would leave a never-written cell unknown for good
    always_ff @(posedge clk) begin
      if (port.en && port.we && port.lanes[g]) begin
        bank[port.addr] <= port.wdata[g*BYTE_W +: BYTE_W];
      end
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rd_r <= '0;
      end else if (port.en && !port.we && port.lanes[g]) begin
        rd_r <= bank[port.addr];
      end else begin
        rd_r <= '0;
      end
    end
    assign port.rdata[g*BYTE_W +: BYTE_W] = rd_r;
  end
endmodule
`default_nettype wire

// ===== rom_pkg.sv
/*
  Shared constants, types and lane decoding for the on-chip program store.
  Assumes a single 20 MHz clock and a big-endian 32-bit internal bus.
*/
`default_nettype none
package rom_pkg;
  localparam int ROM_BYTES = 65536;
  localparam int WORD_BYTES = 4;
  localparam int ROM_WORDS = ROM_BYTES / WORD_BYTES;
  localparam int WADDR_W = 14;
  localparam int BUS_ADDR_W = 28;
  localparam int BUS_DATA_W = 32;
  localparam int LANES = 4;
  localparam int BYTE_W = 8;
  localparam int AREA_HI = 26;
  localparam int AREA_LO = 24;
  localparam int ROM_OFF_HI = 15;
  localparam int WORD_LSB = 2;
  localparam int PROG_ADDR_W = 17;
  localparam int PROG_HALF_BIT = 16;
  localparam logic [2:0] MODE_PINS_EXT8 = 3'h0;
  localparam logic [2:0] MODE_PINS_EXT16 = 3'h1;
  localparam logic [2:0] MODE_PINS_ROM = 3'h2;
  localparam logic [2:0] MODE_PINS_PROM = 3'h7;
  localparam logic [2:0] AREA0_SEL = 3'h0;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LANES_ALL = 4'hF;
  localparam logic [3:0] LANE_FIRST = 4'h8;
  localparam logic [3:0] LANES_HI = 4'hC;
  localparam logic [3:0] LANES_LO = 4'h3;
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_OE_MAX_NS = 150;
  localparam int T_OE_CYC = T_OE_MAX_NS / CLK_PERIOD_NS;
  localparam int T_DF_MAX_NS = 130;
  localparam int T_DF_CYC = T_DF_MAX_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SIZE_BYTE, SIZE_HALF, SIZE_WORD, SIZE_RSVD} size_e;
  typedef enum logic {MASTER_CPU, MASTER_DMA} master_e;
  typedef enum logic [2:0] {MODE_EXT8, MODE_EXT16, MODE_ROM, MODE_PROM, MODE_RSVD} mode_e;

  // byte lane enables; offset 0 of a word sits in bits 31:24
  function automatic logic [3:0] lane_mask(size_e sz, logic [1:0] a);
    unique case (sz)
      SIZE_BYTE: lane_mask = LANE_FIRST >> a;
      SIZE_HALF: lane_mask = a[1] ? LANES_LO : LANES_HI;
      default: lane_mask = LANES_ALL;
    endcase
  endfunction
endpackage
`default_nettype wire

// ===== testbench.sv
/*
  Self-checking bench for the on-chip program store.
  Assumes rom_pkg and the store files are compiled first; the bench plays the programmer.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rom_pkg::*;
  localparam int PULSE_CYC = 4000; // 0.2 ms at 50 ns
  typedef struct packed {
    master_e m;
    size_e s;
    logic w;
    logic [27:0] a;
    logic [1:0] ke;
    logic [31:0] d;
  } row_s;
  logic ref_clk, rst_n, bus_req, bus_write, bus_ack, bus_err;
  logic [2:0] op_mode_pins;
  master_e bus_master;
  size_e bus_size;
  logic [27:0] bus_addr;
  logic [31:0] bus_rdata, rd;
  logic rom_enabled, area0_external, area0_bus16, prom_mode;
  logic prog_ce_n, prog_oe_n, program_pulse_n, prog_data_lines_oe;
  logic [16:0] prog_address_lines;
  logic [7:0] prog_data_lines_i, prog_data_lines_o;
  logic [1:0] ke;
  int err_total, n_tests, miss_run;
  logic [16:0] pa [5] = '{17'h00000, 17'h00001, 17'h00002, 17'h00003, 17'h0FFFF};
  logic [7:0] pd [5] = '{8'h12, 8'h34, 8'h56, 8'h78, 8'hA5};
  logic [2:0] md [5] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2};
  logic [3:0] mx [5] = '{4'h4, 4'h6, 4'h0, 4'h1, 4'h8};
  logic [2:0] fl [4] = '{3'b000, 3'b011, 3'b100, 3'b111};
  row_s rows [12] = '{
    '{MASTER_CPU, SIZE_WORD, 1'b0, 28'h0000000, 2'h2, 32'h12345678},
    '{MASTER_CPU, SIZE_HALF, 1'b0, 28'h0000002, 2'h2, 32'h00005678},
    '{MASTER_CPU, SIZE_HALF, 1'b0, 28'h0000001, 2'h2, 32'h12340000},
    '{MASTER_CPU, SIZE_BYTE, 1'b0, 28'h0000001, 2'h2, 32'h00340000},
    '{MASTER_DMA, SIZE_BYTE, 1'b0, 28'h8000003, 2'h2, 32'h00000078},
    '{MASTER_DMA, SIZE_HALF, 1'b0, 28'h0FF0002, 2'h2, 32'h00005678},
    '{MASTER_DMA, SIZE_WORD, 1'b0, 28'h0000000, 2'h1, 32'h0},
    '{MASTER_CPU, SIZE_RSVD, 1'b0, 28'h0000000, 2'h1, 32'h0},
    '{MASTER_CPU, SIZE_BYTE, 1'b0, 28'h800FFFF, 2'h2, 32'h000000A5},
    '{MASTER_CPU, SIZE_WORD, 1'b1, 28'h0000000, 2'h2, 32'h0},
    '{MASTER_CPU, SIZE_WORD, 1'b0, 28'h8010000, 2'h2, 32'h12345678},
    '{MASTER_CPU, SIZE_WORD, 1'b0, 28'h1000000, 2'h0, 32'h0}};

  onchip_rom dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .op_mode_pins(op_mode_pins),
    .bus_req(bus_req), .bus_master(bus_master), .bus_size(bus_size),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_ack(bus_ack), .bus_err(bus_err),
    .bus_rdata(bus_rdata), .rom_enabled(rom_enabled), .area0_external(area0_external),
    .area0_bus16(area0_bus16), .prom_mode(prom_mode), .prog_ce_n(prog_ce_n),
    .prog_oe_n(prog_oe_n), .program_pulse_n(program_pulse_n),
    .prog_address_lines(prog_address_lines), .prog_data_lines_i(prog_data_lines_i),
    .prog_data_lines_o(prog_data_lines_o), .prog_data_lines_oe(prog_data_lines_oe));
  bus_agent bm_u (.clk(ref_clk), .req(bus_req), .master(bus_master), .size(bus_size),
    .write(bus_write), .addr(bus_addr), .ack(bus_ack), .err(bus_err), .rdata(bus_rdata));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pins(input logic [2:0] c, input logic [16:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {prog_ce_n, prog_oe_n, program_pulse_n} <= c;
    prog_address_lines <= a;
    prog_data_lines_i <= d;
  endtask
  task automatic prog_byte(input logic [16:0] a, input logic [7:0] d);
    if (miss_run >= 2) return;
    pins(3'b010, a, d);
    step(PULSE_CYC);
    pins(3'b011, a, ~d);
  endtask
  // the bench drives a fixed 5A on the data input pins during verify, and A5 after it
  task automatic verify(input logic [16:0] a, input logic [7:0] exp);
    pins(3'b001, a, 8'h5A);
    step(3);
    check(prog_data_lines_oe, 1'b1);
    check(prog_data_lines_o, exp);
    miss_run = (prog_data_lines_o === exp) ? 0 : miss_run + 1;
    pins(3'b011, a, 8'hA5);
    step(2);
    check(prog_data_lines_oe, 1'b0);
  endtask

  initial begin
    step(60000);
    err_total++;
    close_out();
  end

  initial begin
    err_total = 0;
    n_tests = 0;
    miss_run = 0;
    rst_n = 1'b0;
    op_mode_pins = MODE_PINS_PROM;
    {prog_ce_n, prog_oe_n, program_pulse_n} = 3'b111;
    prog_address_lines = 17'h00000;
    prog_data_lines_i = 8'h00;
    step(3);
    check({rom_enabled, area0_external, area0_bus16, prom_mode}, 4'h4);
    check(prog_data_lines_oe, 1'b0);
    rst_n <= 1'b1;
    step(2);
    check({rom_enabled, prom_mode}, 2'b01);
    for (int i = 0; i < 5; i++) begin
      prog_byte(pa[i], pd[i]);
      verify(pa[i], pd[i]);
    end
    prog_byte(17'h00000, 8'h12);
    verify(17'h00000, 8'h12);
    prog_byte(17'h10000, 8'h00);
    verify(17'h10000, ERASED_BYTE);
    prog_byte(17'h00005, 8'hC3);
    // holding the write code while the address moves must not write a second byte
    pins(3'b010, 17'h00004, 8'h00);
    step(PULSE_CYC);
    pins(3'b010, 17'h00005, 8'h00);
    step(10);
    pins(3'b011, 17'h00005, 8'hFF);
    verify(17'h00004, 8'h00);
    verify(17'h00005, 8'hC3);
    for (int i = 0; i < 4; i++) begin
      pins(fl[i], 17'h00000, 8'h3C);
      step(3);
      check(prog_data_lines_oe, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      op_mode_pins <= md[i];
      step(2);
      check({rom_enabled, area0_external, area0_bus16, prom_mode}, mx[i]);
      bm_u.access(MASTER_CPU, SIZE_WORD, 1'b0, 28'h0000000, ke, rd);
      check(ke, {mx[i][3], 1'b0});
    end
    foreach (rows[i]) begin
      bm_u.access(rows[i].m, rows[i].s, rows[i].w, rows[i].a, ke, rd);
      check(ke, rows[i].ke);
      if (rows[i].ke == 2'h2 && !rows[i].w) check(rd, rows[i].d);
    end
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #10;
    check({rom_enabled, area0_external, bus_ack, bus_err}, 4'h4);
    @(posedge ref_clk);
    rst_n <= 1'b1;
    step(2);
    check({rom_enabled, area0_external, area0_bus16, prom_mode}, 4'h8);
    // the cells have no reset, so the byte programmed at the top of the store still reads back
    bm_u.access(MASTER_DMA, SIZE_BYTE, 1'b0, 28'h000FFFF, ke, rd);
    check(ke, 2'h2);
    check(rd, 32'h000000A5);
    close_out();
  end
endmodule
`default_nettype wire
